// ===== verilog/nrs_pkg.sv
// Purpose: Shared constants for the negate and return stack execution block.
// Assumes: One core clock; software drives the block over an AHB-Lite slave port.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
// Function
// - Negate opcode 0110 110a ffff ffff writes inverted register plus one and sets flags.
// - Bank-access bit 0 resolves the register field against the fixed Access Bank.
// - Bank-access bit 1 joins bank select register and register field for the address.
// - Extended set, bit 0 and field up to 95 use indexed literal offset instead.
// - Pop word 0006 discards top of stack, exposing the older entry, flags untouched.
// - Word 0005 decodes as push, one word, flags untouched.
// - Push writes program counter plus 2 into the top-of-stack entry.
// - Push keeps the earlier top-of-stack entry one level deeper.
package nrs_pkg;
    // Widths of the core datapath.
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int PC_W = 21;
    localparam int INSTR_W = 16;
    localparam int BANK_W = 4;
    localparam int FLAG_W = 5;
    localparam int STK_DEPTH = 31;
    localparam int STK_PTR_W = 5;

    // Register byte offsets on the bus.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BANK = 8'h04;
    localparam logic [7:0] OFS_INSTR = 8'h08;
    localparam logic [7:0] OFS_PC = 8'h0c;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_TOP = 8'h14;
    localparam logic [7:0] OFS_DEPTH = 8'h18;
    localparam logic [7:0] OFS_INDEX = 8'h1c;
    localparam logic [7:0] OFS_MADDR = 8'h20;
    localparam logic [7:0] OFS_MDATA = 8'h24;

    // Flag bit positions in the flags register.
    localparam int FLG_C = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_N = 4;

    // Instruction register status bits seen on read.
    localparam int INSTR_BUSY_BIT = 17;
    localparam int INSTR_UNK_BIT = 16;

    // Opcode patterns.
    localparam logic [6:0] OPC_NEGATE = 7'h36;
    localparam logic [15:0] OPC_POP = 16'h0006;
    localparam logic [15:0] OPC_PUSH = 16'h0005;
    localparam logic [15:0] OPC_ZERO = 16'h0000;
    localparam logic [3:0] OPC_NOP_HI = 4'hf;

    // Address formation constants.
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] INDEX_MAX = 8'h5f;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [DATA_W-1:0] SIGN_ONLY = 8'h80;

    // Bus encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;

    // Quarter-cycle sequencer, one-hot.
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_Q1 = 5'b00010,
        ST_Q2 = 5'b00100,
        ST_Q3 = 5'b01000,
        ST_Q4 = 5'b10000
    } nrs_state_e;
endpackage

// ===== verilog/nrs_stack_if.sv
// Purpose: Carries push and pop requests between the core and its return stack.
// Assumes: Requests are one-cycle pulses on the core clock.
// Notes: The stack answers with its current top and depth combinationally.
`timescale 1ns/1ps
interface nrs_stack_if #(parameter int PC_W = 21, parameter int PTR_W = 5);
    logic pushReq;
    logic popReq;
    logic [PC_W-1:0] pushAddr;
    logic [PC_W-1:0] topAddr;
    logic [PTR_W-1:0] depth;
    modport core (output pushReq, output popReq, output pushAddr,
        input topAddr, input depth);
    modport stack (input pushReq, input popReq, input pushAddr,
        output topAddr, output depth);
endinterface

// ===== verilog/nrs_return_stack.sv
// Purpose: Hardware return stack of program addresses.
// Assumes: Push and pop never arrive in the same cycle.
// Notes: A push to a full stack and a pop of an empty one are ignored.
`timescale 1ns/1ps
module nrs_return_stack
    import nrs_pkg::*;
#(
    parameter int DEPTH = STK_DEPTH
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Link to the core.
    nrs_stack_if.stack stk
);
    logic [PC_W-1:0] slotMem [DEPTH];
    logic [STK_PTR_W-1:0] ptr_reg;
    logic canPush;
    logic canPop;

    // The newest entry sits just below the pointer, so older ones stay put.
    assign canPush = stk.pushReq && (ptr_reg < STK_PTR_W'(DEPTH));
    assign canPop = stk.popReq && (ptr_reg != '0);
    assign stk.topAddr = (ptr_reg == '0) ? '0 : slotMem[ptr_reg - 1'b1];
    assign stk.depth = ptr_reg;

    // Pointer moves up on push and down on pop.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_reg <= '0;
        end else if (canPush) begin
            ptr_reg <= ptr_reg + 1'b1;
        end else if (canPop) begin
            ptr_reg <= ptr_reg - 1'b1;
        end
    end

    // Entry storage; no reset needed since the pointer guards reads.
    always_ff @(posedge ref_clk) begin
        if (canPush) begin
            slotMem[ptr_reg] <= stk.pushAddr;
        end
    end
endmodule

// ===== verilog/nrs_exec_top.sv
// Purpose: Executes negate, no-operation, pop and push words for the core.
// Assumes: Software loads words through the bus; AHB-Lite single word transfers.
// Notes: Each word takes one instruction cycle of four quarter clocks.
`timescale 1ns/1ps
module nrs_exec_top
    import nrs_pkg::*;
#(
    parameter int MEM_WORDS = 4096
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // AHB-Lite slave request.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // AHB-Lite slave answer.
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    // Data memory and the stack link.
    logic [DATA_W-1:0] dataMem [MEM_WORDS];
    nrs_stack_if #(.PC_W(PC_W), .PTR_W(STK_PTR_W)) stkLink ();

    // Architectural and sequencing state.
    // Operand and result sit in their own registers so that each quarter has one job.
    nrs_state_e state_reg;
    nrs_state_e state_next;
    logic extEn_reg;
    logic [BANK_W-1:0] bank_reg;
    logic [PC_W-1:0] pc_reg;
    logic [FLAG_W-1:0] flags_reg;
    logic [ADDR_W-1:0] index_reg;
    logic [ADDR_W-1:0] memAddr_reg;
    logic [INSTR_W-1:0] instr_reg;
    logic unknown_reg;
    logic [ADDR_W-1:0] opAddr_reg;
    logic [DATA_W-1:0] operand_reg;
    logic [DATA_W-1:0] result_reg;
    logic pushReq_reg;
    logic popReq_reg;

    // Bus state.
    logic apValid_reg;
    logic apWrite_reg;
    logic [7:0] apAddr_reg;
    logic hreadyout_reg;
    logic [31:0] hrdata_reg;
    logic hresp_reg;

    // Resolves the eight-bit field into a data memory address.
    // Indexed offsets wrap within the memory, so a large base plus field folds back to low.
    // The Access Bank split keeps low field values on bank zero and the rest on the top bank.
    function automatic logic [ADDR_W-1:0] resolveAddr(
        input logic [DATA_W-1:0] field,
        input logic accessBit,
        input logic extEnable,
        input logic [BANK_W-1:0] bank,
        input logic [ADDR_W-1:0] indexBase
    );
        logic [ADDR_W-1:0] addr;
        addr = {bank, field};
        if (!accessBit) begin
            if (extEnable && (field <= INDEX_MAX)) begin
                addr = indexBase + ADDR_W'(field);
            end else if (field < ACCESS_SPLIT) begin
                addr = {ACCESS_LO_BANK, field};
            end else begin
                addr = {ACCESS_HI_BANK, field};
            end
        end
        return addr;
    endfunction

    // Instruction decode.
    // Decode is consulted only from Q1 on, and loads are refused while busy,
    // so a new word can never race the decision for the word in flight.
    logic isNegate;
    logic isPop;
    logic isPush;
    logic isNop;
    logic [ADDR_W-1:0] decodedAddr;
    assign isNegate = (instr_reg[15:9] == OPC_NEGATE);
    assign isPop = (instr_reg == OPC_POP);
    assign isPush = (instr_reg == OPC_PUSH);
    assign isNop = (instr_reg == OPC_ZERO) || (instr_reg[15:12] == OPC_NOP_HI);
    assign decodedAddr = resolveAddr(instr_reg[7:0], instr_reg[8], extEn_reg,
        bank_reg, index_reg);

    // Negation and its flags; computed as the inverted operand plus one.
    // Carry and digit carry are set only when the operand, or its low nibble, is zero,
    // because only then does the added one ripple all the way out.
    logic [DATA_W-1:0] negValue;
    logic [FLAG_W-1:0] negFlags;
    assign negValue = ~operand_reg + 1'b1;
    assign negFlags[FLG_C] = (operand_reg == '0);
    assign negFlags[FLG_DC] = (operand_reg[3:0] == 4'h0);
    assign negFlags[FLG_OV] = (operand_reg == SIGN_ONLY);
    assign negFlags[FLG_Z] = (result_reg == '0);
    assign negFlags[FLG_N] = result_reg[DATA_W-1];

    // Bus address phase decode.
    // Writes act on the registered address phase so that hwdata is taken in its data phase.
    // A word or PC write while busy is dropped rather than queued, which keeps the
    // sequencer simple; software must poll the busy bit first.
    logic apTake;
    logic wrCtrl;
    logic wrBank;
    logic wrInstr;
    logic wrPc;
    logic wrFlags;
    logic wrIndex;
    logic wrMaddr;
    logic wrMdata;
    logic busy;
    assign apTake = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign busy = (state_reg != ST_IDLE);
    assign wrCtrl = apValid_reg && apWrite_reg && (apAddr_reg == OFS_CTRL);
    assign wrBank = apValid_reg && apWrite_reg && (apAddr_reg == OFS_BANK);
    assign wrInstr = apValid_reg && apWrite_reg && (apAddr_reg == OFS_INSTR) && !busy;
    assign wrPc = apValid_reg && apWrite_reg && (apAddr_reg == OFS_PC) && !busy;
    assign wrFlags = apValid_reg && apWrite_reg && (apAddr_reg == OFS_FLAGS);
    assign wrIndex = apValid_reg && apWrite_reg && (apAddr_reg == OFS_INDEX);
    assign wrMaddr = apValid_reg && apWrite_reg && (apAddr_reg == OFS_MADDR);
    assign wrMdata = apValid_reg && apWrite_reg && (apAddr_reg == OFS_MDATA);

    // Read data selection; unmapped offsets read as zero.
    // The word is chosen in the address phase, so a read overlapped with a write to the
    // same register would return the old value; masters here never overlap them.
    logic [7:0] rdOfs;
    logic [31:0] rdWord;
    assign rdOfs = haddr[7:0];
    assign rdWord = (haddr[31:8] != '0) ? 32'h00000000 :
        (rdOfs == OFS_CTRL) ? 32'(extEn_reg) :
        (rdOfs == OFS_BANK) ? 32'(bank_reg) :
        (rdOfs == OFS_INSTR) ? {14'h0000, busy, unknown_reg, instr_reg} :
        (rdOfs == OFS_PC) ? 32'(pc_reg) :
        (rdOfs == OFS_FLAGS) ? 32'(flags_reg) :
        (rdOfs == OFS_TOP) ? 32'(stkLink.topAddr) :
        (rdOfs == OFS_DEPTH) ? 32'(stkLink.depth) :
        (rdOfs == OFS_INDEX) ? 32'(index_reg) :
        (rdOfs == OFS_MADDR) ? 32'(memAddr_reg) :
        (rdOfs == OFS_MDATA) ? 32'(dataMem[memAddr_reg]) : 32'h00000000;

    // The slave never stalls, so every transfer completes in one data phase.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            apValid_reg <= 1'b0;
            apWrite_reg <= 1'b0;
            apAddr_reg <= '0;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= '0;
            hresp_reg <= HRESP_OKAY;
        end else begin
            apValid_reg <= apTake;
            apWrite_reg <= hwrite;
            apAddr_reg <= (haddr[31:8] != '0) ? 8'hff : haddr[7:0];
            hrdata_reg <= (apTake && !hwrite) ? rdWord : hrdata_reg;
            hresp_reg <= HRESP_OKAY;
        end
    end

    assign hreadyout = hreadyout_reg;
    // The response comes from a flip-flop like every other output, though it never moves.
    assign hresp = hresp_reg;
    assign hrdata = hrdata_reg;

    // Quarter sequencer: a word written while idle starts one cycle of four quarters.
    // Each quarter lasts one clock here, so a word costs four clocks of busy time.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: state_next = wrInstr ? ST_Q1 : ST_IDLE;
            ST_Q1: state_next = ST_Q2;
            ST_Q2: state_next = ST_Q3;
            ST_Q3: state_next = ST_Q4;
            ST_Q4: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Software-owned configuration.
    // The extended set bit only changes how a bank-access bit of zero is resolved.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            extEn_reg <= 1'b0;
            bank_reg <= '0;
            index_reg <= '0;
            memAddr_reg <= '0;
        end else begin
            extEn_reg <= wrCtrl ? hwdata[0] : extEn_reg;
            bank_reg <= wrBank ? hwdata[BANK_W-1:0] : bank_reg;
            index_reg <= wrIndex ? hwdata[ADDR_W-1:0] : index_reg;
            memAddr_reg <= wrMaddr ? hwdata[ADDR_W-1:0] : memAddr_reg;
        end
    end

    // Instruction word; an unsupported word is flagged, cleared by the next load.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_reg <= OPC_ZERO;
            unknown_reg <= 1'b0;
        end else if (wrInstr) begin
            instr_reg <= hwdata[INSTR_W-1:0];
            unknown_reg <= 1'b0;
        end else if (state_reg == ST_Q1) begin
            unknown_reg <= !(isNegate || isPop || isPush || isNop);
        end
    end

    // Operand address at decode, read in Q2, compute in Q3.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            opAddr_reg <= '0;
            operand_reg <= '0;
            result_reg <= '0;
        end else begin
            opAddr_reg <= (state_reg == ST_Q1) ? decodedAddr : opAddr_reg;
            operand_reg <= (state_reg == ST_Q2) ? dataMem[opAddr_reg] : operand_reg;
            result_reg <= (state_reg == ST_Q3) ? negValue : result_reg;
        end
    end

    // Flags change only for the negate; the execution update wins over software.
    // A software write in that same cycle is lost; the busy bit tells when it is safe.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg <= '0;
        end else if ((state_reg == ST_Q4) && isNegate) begin
            flags_reg <= negFlags;
        end else if (wrFlags) begin
            flags_reg <= hwdata[FLAG_W-1:0];
        end
    end

    // Program counter steps to the next word at the end of every cycle.
    // No-operation and unsupported words advance it too, as an in-line fetch would.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg <= '0;
        end else if (wrPc) begin
            pc_reg <= hwdata[PC_W-1:0];
        end else if (state_reg == ST_Q4) begin
            pc_reg <= pc_reg + PC_STEP;
        end
    end

    // Stack requests are single pulses: push lands in Q2, pop in Q3.
    // The push uses the PC before its Q4 step, so the saved address is the next word;
    // registering the requests keeps the stack timing apart from the decode path.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pushReq_reg <= 1'b0;
            popReq_reg <= 1'b0;
        end else begin
            pushReq_reg <= (state_reg == ST_Q1) && isPush;
            popReq_reg <= (state_reg == ST_Q2) && isPop;
        end
    end

    assign stkLink.pushReq = pushReq_reg;
    assign stkLink.popReq = popReq_reg;
    assign stkLink.pushAddr = pc_reg + PC_STEP;

    // Memory writes: the negate result in Q4 takes priority over a bus write.
    // Software is expected to wait for idle before touching MDATA, so nothing is lost.
    logic memWrExec;
    assign memWrExec = (state_reg == ST_Q4) && isNegate;
    always_ff @(posedge ref_clk) begin
        if (memWrExec) begin
            dataMem[opAddr_reg] <= result_reg;
        end else if (wrMdata) begin
            dataMem[memAddr_reg] <= hwdata[DATA_W-1:0];
        end
    end

    // Return stack; its older entries stay beneath each new push.
    // Full and empty cases are absorbed inside the stack, so the core never checks depth.
    nrs_return_stack #(.DEPTH(STK_DEPTH)) uStack (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .stk(stkLink.stack)
    );

    // Size of the transfer is fixed at one word, so hsize is not decoded.
    // A narrow transfer would still act on the whole word; masters must issue words only.
    logic unusedSize;
    assign unusedSize = ^hsize;
endmodule

// ===== verif/nrs_exec_props.sv
// Purpose: Bus-side assertions for the negate and return stack execution block.
// Assumes: One slave, so hready follows hreadyout.
// Notes: Busy time and stack depth are shadowed from bus traffic alone.
`timescale 1ns/1ps
module nrs_exec_props
    import nrs_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bus request.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // Bus answer.
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata
);
    logic wrInstr_reg;
    logic [2:0] busyCnt_reg;
    logic [4:0] depth_reg;
    // Transfer decode; a word runs for four cycles after its write lands.
    wire logic take = hsel && hready && (htrans == HTRANS_NONSEQ);
    wire logic rdTake = take && !hwrite;
    wire logic busyNow = (busyCnt_reg != 3'h0);
    wire logic go = wrInstr_reg && hready && !busyNow;
    wire logic doPush = go && (hwdata[15:0] == OPC_PUSH) && (depth_reg != 5'h1f);
    wire logic doPop = go && (hwdata[15:0] == OPC_POP) && (depth_reg != 5'h0);
    // Shadow counters; a write while busy is dropped, as the design must do.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrInstr_reg <= 1'b0;
            busyCnt_reg <= 3'h0;
            depth_reg <= 5'h0;
        end else begin
            wrInstr_reg <= take && hwrite && (haddr == 32'(OFS_INSTR));
            busyCnt_reg <= go ? 3'h4 : busyCnt_reg - {2'h0, busyNow};
            depth_reg <= depth_reg + {4'h0, doPush} - {4'h0, doPop};
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (hresp == HRESP_OKAY) else $error("hresp not okay");
    a_rdata_hold: assert property (!rdTake |=> $stable(hrdata)) else $error("hrdata moved");
    a_unmapped_zero: assert property (rdTake && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_busy_window: assert property (rdTake && haddr == 32'(OFS_INSTR)
        |=> hrdata[INSTR_BUSY_BIT] == $past(busyNow)) else $error("busy flag wrong");
    a_depth_track: assert property (rdTake && haddr == 32'(OFS_DEPTH) && !busyNow
        |=> hrdata == {27'h0, $past(depth_reg)}) else $error("stack depth wrong");
    a_top_width: assert property (rdTake && haddr == 32'(OFS_TOP)
        |=> hrdata[31:PC_W] == '0) else $error("top wider than pc");
    a_flags_width: assert property (rdTake && haddr == 32'(OFS_FLAGS)
        |=> hrdata[31:FLAG_W] == '0) else $error("flags wider than five");
endmodule

bind nrs_exec_top nrs_exec_props u_props (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata);

// ===== verif/tb_negate_and_return_stack_ops.sv
// Purpose: Self-checking bench for the execution block over its bus.
// Assumes: Zero-wait slave; each word is written then polled until idle.
// Notes: Expected values come from two's complement and stack arithmetic.
`timescale 1ns/1ps
module tb_negate_and_return_stack_ops;
    import nrs_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp;
    logic [31:0] hrdata, rd;
    wire logic hready = hreadyout;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    nrs_exec_top dut_u (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hresp, .hrdata);
    // Clock; a run far past the expected length counts as a hang.
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask
    // One single transfer; request held until hready is seen high.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, 32'(a), d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, 32'(a), 32'h0);
        chk(nm, exp, rd);
    endtask
    task automatic poll(output int n);
        n = 0;
        bus(1'b0, 32'(OFS_INSTR), 32'h0);
        while (rd[INSTR_BUSY_BIT] === 1'b1 && n < 20) begin
            n++;
            bus(1'b0, 32'(OFS_INSTR), 32'h0);
        end
    endtask
    // A one-cycle word shows busy on exactly two back-to-back polls.
    task automatic exec(input logic [15:0] w);
        int n;
        wr(OFS_INSTR, {16'h0, w});
        poll(n);
        chk("busy polls", 32'h2, 32'(n));
    endtask
    task automatic mem(input logic [11:0] a, input logic [7:0] d);
        wr(OFS_MADDR, {20'h0, a});
        wr(OFS_MDATA, {24'h0, d});
    endtask
    task automatic t_reset();
        logic [7:0] ofs [6] = '{OFS_CTRL, OFS_BANK, OFS_PC, OFS_FLAGS, OFS_TOP, OFS_DEPTH};
        foreach (ofs[i]) rdc("reset value", ofs[i], 32'h0);
        wr(8'h0, 32'h0);
        bus(1'b1, 32'h100, 32'h55);
        bus(1'b0, 32'h100, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("t_reset done");
    endtask
    // Sign, zero, digit and overflow corners of the negate result.
    task automatic t_negate();
        logic [7:0] v [4] = '{8'h3a, 8'h00, 8'h80, 8'h01};
        logic [7:0] r [4] = '{8'hc6, 8'h00, 8'h80, 8'hff};
        logic [4:0] f [4] = '{5'h10, 5'h07, 5'h1a, 5'h10};
        wr(OFS_BANK, 32'h3);
        wr(OFS_PC, 32'h0);
        foreach (v[i]) begin
            mem(12'h33a, v[i]);
            wr(OFS_FLAGS, {27'h0, ~f[i]});
            exec(16'h6d3a);
            rdc("negate result", OFS_MDATA, {24'h0, r[i]});
            rdc("negate flags", OFS_FLAGS, {27'h0, f[i]});
        end
        rdc("pc after four", OFS_PC, 32'h8);
        $display("t_negate done");
    endtask
    // Access Bank halves, indexed offset up to 0x5f, and banked with the extension on.
    task automatic t_modes();
        logic [15:0] w [6] = '{16'h6c10, 16'h6ca0, 16'h6c10, 16'h6c5f, 16'h6c60, 16'h6d10};
        logic [11:0] a [6] = '{12'h010, 12'hfa0, 12'h210, 12'h25f, 12'hf60, 12'h310};
        wr(OFS_INDEX, 32'h200);
        foreach (w[i]) begin
            wr(OFS_CTRL, {31'h0, i > 1});
            mem(a[i], 8'h05);
            exec(w[i]);
            wr(OFS_MADDR, {20'h0, a[i]});
            rdc("mode target", OFS_MDATA, 32'hfb);
        end
        wr(OFS_CTRL, 32'h0);
        $display("t_modes done");
    endtask
    task automatic t_stack();
        wr(OFS_FLAGS, 32'h1f);
        wr(OFS_PC, 32'h124);
        exec(OPC_PUSH);
        rdc("top", OFS_TOP, 32'h126);
        exec(OPC_PUSH);
        rdc("top", OFS_TOP, 32'h128);
        rdc("depth", OFS_DEPTH, 32'h2);
        exec(OPC_POP);
        rdc("top", OFS_TOP, 32'h126);
        rdc("depth", OFS_DEPTH, 32'h1);
        exec(OPC_POP);
        exec(OPC_POP);
        rdc("depth", OFS_DEPTH, 32'h0);
        rdc("flags", OFS_FLAGS, 32'h1f);
        rdc("pc", OFS_PC, 32'h12e);
        $display("t_stack done");
    endtask
    // No-ops leave flags and stack alone but advance the PC; a word written while busy must be dropped.
    task automatic t_nop();
        int n;
        wr(OFS_FLAGS, 32'ha);
        wr(OFS_PC, 32'h0);
        exec(OPC_ZERO);
        exec(16'hf123);
        rdc("flags", OFS_FLAGS, 32'ha);
        rdc("depth", OFS_DEPTH, 32'h0);
        rdc("pc", OFS_PC, 32'h4);
        exec(16'h1234);
        rdc("unknown flag", OFS_INSTR, 32'h00011234);
        rdc("unknown keeps flags", OFS_FLAGS, 32'ha);
        exec(OPC_ZERO);
        rdc("unknown cleared", OFS_INSTR, 32'h00000000);
        wr(OFS_INSTR, 32'(OPC_PUSH));
        wr(OFS_INSTR, 32'(OPC_POP));
        poll(n);
        rdc("busy drop", OFS_DEPTH, 32'h1);
        exec(OPC_POP);
        $display("t_nop done");
    endtask
    // A reset in mid-word cancels it and empties the stack; the bus stays ready throughout.
    task automatic t_restart();
        wr(OFS_PC, 32'h40);
        exec(OPC_PUSH);
        wr(OFS_INSTR, 32'(OPC_PUSH));
        rst_n <= 1'b0;
        @(posedge ref_clk);
        chk("reset ready", 32'h1, 32'(hreadyout));
        chk("reset resp", 32'(HRESP_OKAY), 32'(hresp));
        chk("reset rdata", 32'h0, hrdata);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rdc("restart instr", OFS_INSTR, 32'h0);
        rdc("restart depth", OFS_DEPTH, 32'h0);
        rdc("restart pc", OFS_PC, 32'h0);
        exec(OPC_PUSH);
        rdc("restart top", OFS_TOP, 32'h2);
        exec(OPC_POP);
        rdc("restart empty", OFS_DEPTH, 32'h0);
        $display("t_restart done");
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_negate();
        t_modes();
        t_stack();
        t_nop();
        t_restart();
        wrap_up();
    end
endmodule
